// >>> conv_port_pkg.sv
// Function
// - Each channel samples on the rising edge of its own sample clock.
// - Select high: channel A on bus A, channel B on bus B.
// - Select low: buses swapped, channel A on bus B, B on A.
// - Power-down low, enable low: convert and drive outputs.
// - Power-down low, enable high: convert, outputs high impedance.
// - Power-down high, enable low: nap, outputs high impedance.
// - Power-down high, enable high: sleep, outputs high impedance.
// - Each bus carries a 12-bit result, highest bit most significant.
// - Range flag high when the delivered sample over or underflowed.
// - Levels 0 and 1 offset binary, levels 2 and 3 two's complement.
// - Stabilizer on at levels 1 and 2, off at 0 and 3.
// - Result appears five sample clock cycles after its sampling edge.
//
package conv_port_pkg;

   localparam int DATA_W       = 12;
   localparam int MSB_POS      = 11;
   localparam int LATENCY      = 5;
   localparam int REG_STATUS   = 32'h0000_0000;
   localparam int REG_MASK     = 32'h0000_0004;
   localparam int REG_CTRL     = 32'h0000_0008;
   localparam int CTRL_FMT_LO  = 0;
   localparam int CTRL_FMT_HI  = 1;
   localparam int IRQ_W        = 4;
   localparam int IRQ_OVR_A    = 0;
   localparam int IRQ_OVR_B    = 1;
   localparam int IRQ_MODE_A   = 2;
   localparam int IRQ_MODE_B   = 3;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // Channel power states, Gray along run -> hiz -> nap -> sleep
   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_HIZ   = 2'b01,
      ST_NAP   = 2'b11,
      ST_SLEEP = 2'b10
   } power_e;

   typedef struct packed {
      logic [DATA_W-1:0] code;
      logic              range;
   } sample_s;

   // Decode format level: high half selects two's complement
   function automatic logic fmt_twos(input logic [1:0] lvl);
      return lvl[1];
   endfunction

   // Decode stabilizer: middle levels only
   function automatic logic dcs_on(input logic [1:0] lvl);
      return lvl[1] ^ lvl[0];
   endfunction

endpackage

// >>> conv_channel.sv
`timescale 1ns/1ns
`default_nettype none
module conv_channel (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   input  wire logic                    ce,
   // Controls
   input  wire logic                    sample_clock,
   input  wire logic                    power_down,
   input  wire logic                    out_en_n,
   input  wire logic                    twos,
   input  wire logic [11:0]             analog_code,
   input  wire logic                    analog_range,
   // Results
   output logic                         sample_tick,
   output conv_port_pkg::sample_s       result,
   output conv_port_pkg::power_e        power_state
);

   typedef struct packed {
      logic                                     clk_d;
      conv_port_pkg::sample_s [4:0]             pipe;
      conv_port_pkg::sample_s                   res;
      logic                                     tick;
      conv_port_pkg::power_e                    pst;
   } state_s;

   state_s st_reg;
   state_s st_next;

   // Pipeline advances once per sample clock rising edge
   always_comb begin
      st_next      = st_reg;
      st_next.tick = 1'b0;
      st_next.clk_d = sample_clock;
      case ({power_down, out_en_n})
         2'b00:   st_next.pst = conv_port_pkg::ST_RUN;
         2'b01:   st_next.pst = conv_port_pkg::ST_HIZ;
         2'b10:   st_next.pst = conv_port_pkg::ST_NAP;
         2'b11:   st_next.pst = conv_port_pkg::ST_SLEEP;
         default: st_next.pst = conv_port_pkg::ST_RUN;
      endcase
      // Nap and sleep freeze the pipeline; no conversion happens
      if (sample_clock && !st_reg.clk_d && !power_down) begin
         st_next.tick = 1'b1;
         st_next.pipe[0].code  = analog_code;
         st_next.pipe[0].range = analog_range;
         for (int i = 1; i < conv_port_pkg::LATENCY; i++) begin
            st_next.pipe[i] = st_reg.pipe[i-1];
         end
         // Leaves the last stage on the fifth edge after sampling
         st_next.res = st_reg.pipe[conv_port_pkg::LATENCY-1];
         if (twos) begin
            st_next.res.code[conv_port_pkg::MSB_POS] =
               ~st_reg.pipe[conv_port_pkg::LATENCY-1]
                  .code[conv_port_pkg::MSB_POS];
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign sample_tick = st_reg.tick;
   assign result      = st_reg.res;
   assign power_state = st_reg.pst;

endmodule
`default_nettype wire

// >>> conv_apb_regs.sv
`timescale 1ns/1ns
`default_nettype none
module conv_apb_regs (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        ce,
   // APB
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Block side
   input  wire logic [3:0]  events,
   input  wire logic [3:0]  live,
   output logic [1:0]       fmt_level,
   output logic             irq
);

   typedef struct packed {
      logic [3:0]  status;
      logic [3:0]  mask;
      logic [1:0]  ctrl;
      logic [31:0] rdata;
      logic        err;
      logic        rdy;
      logic        irq;
   } state_s;

   state_s     st_reg;
   state_s     st_next;
   logic       acc;
   logic       done;
   logic [1:0] idx;

   // Register slot of an address, 3 when nothing answers there
   function automatic logic [1:0] reg_idx(input logic [11:0] a);
      case (32'(a))
         conv_port_pkg::REG_STATUS: return 2'h0;
         conv_port_pkg::REG_MASK:   return 2'h1;
         conv_port_pkg::REG_CTRL:   return 2'h2;
         default:                   return 2'h3;
      endcase
   endfunction

   // One wait state: answer registered on the access cycle
   always_comb begin
      st_next       = st_reg;
      idx           = reg_idx(paddr);
      acc           = psel && penable && !st_reg.rdy;
      done          = psel && penable && st_reg.rdy && pwrite;
      st_next.rdy   = acc;
      st_next.err   = acc && idx == 2'h3;
      st_next.rdata = 32'h0000_0000;
      if (acc && !pwrite) begin
         case (idx)
            2'h0:    st_next.rdata = {24'h00_0000, live, st_reg.status};
            2'h1:    st_next.rdata = {28'h000_0000, st_reg.mask};
            2'h2:    st_next.rdata = {30'h0000_0000, st_reg.ctrl};
            default: st_next.rdata = 32'h0000_0000;
         endcase
      end
      // Write lands only at the edge that sees ready high, not before
      if (done) begin
         case (idx)
            2'h0:    st_next.status = st_reg.status & ~pwdata[3:0];
            2'h1:    st_next.mask   = pwdata[3:0];
            2'h2:    st_next.ctrl   = pwdata[1:0];
            default: st_next.ctrl   = st_reg.ctrl;
         endcase
      end
      // Set wins over a same-cycle clear
      st_next.status = st_next.status | events;
      st_next.irq    = |(st_next.status & st_reg.mask);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg      <= '0;
         st_reg.ctrl <= conv_port_pkg::CTRL_RESET;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign prdata    = st_reg.rdata;
   assign pready    = st_reg.rdy;
   assign pslverr   = st_reg.err;
   assign fmt_level = st_reg.ctrl;
   assign irq       = st_reg.irq;

endmodule
`default_nettype wire

// >>> dual_adc_output_port.sv
`timescale 1ns/1ns
`default_nettype none
module dual_adc_output_port (
   // Clock, reset, enable
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        ce,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   // Channel controls
   input  wire logic        chan_a_sample_clock,
   input  wire logic        chan_b_sample_clock,
   input  wire logic        bus_select,
   input  wire logic        chan_a_power_down,
   input  wire logic        chan_b_power_down,
   input  wire logic        chan_a_out_en_n,
   input  wire logic        chan_b_out_en_n,
   // Quantizer results
   input  wire logic [11:0] chan_a_code,
   input  wire logic        chan_a_range,
   input  wire logic [11:0] chan_b_code,
   input  wire logic        chan_b_range,
   // Output buses, two signals per pin: value and enable
   output logic [11:0]      bus_a_data,
   output logic [11:0]      bus_a_data_oe,
   output logic             bus_a_range_flag,
   output logic             bus_a_range_flag_oe,
   output logic [11:0]      bus_b_data,
   output logic [11:0]      bus_b_data_oe,
   output logic             bus_b_range_flag,
   output logic             bus_b_range_flag_oe,
   // Status
   output logic             stabilizer_on
);

   typedef struct packed {
      conv_port_pkg::sample_s bus_a;
      conv_port_pkg::sample_s bus_b;
      logic                   oe_a;
      logic                   oe_b;
      logic                   dcs;
      conv_port_pkg::power_e  pst_a_d;
      conv_port_pkg::power_e  pst_b_d;
   } state_s;

   state_s                 st_reg;
   state_s                 st_next;
   conv_port_pkg::sample_s res_a;
   conv_port_pkg::sample_s res_b;
   conv_port_pkg::power_e  pst_a;
   conv_port_pkg::power_e  pst_b;
   logic                   tick_a;
   logic                   tick_b;
   logic [1:0]             fmt_level;
   logic                   twos;
   logic [3:0]             events;
   logic [3:0]             live;

   ////////////////////////////////////////////////////////////////////
   // Shared format level drives both channels
   assign twos = conv_port_pkg::fmt_twos(fmt_level);

   conv_channel u_chan_a (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .ce           (ce),
      .sample_clock (chan_a_sample_clock),
      .power_down   (chan_a_power_down),
      .out_en_n     (chan_a_out_en_n),
      .twos         (twos),
      .analog_code  (chan_a_code),
      .analog_range (chan_a_range),
      .sample_tick  (tick_a),
      .result       (res_a),
      .power_state  (pst_a)
   );

   conv_channel u_chan_b (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .ce           (ce),
      .sample_clock (chan_b_sample_clock),
      .power_down   (chan_b_power_down),
      .out_en_n     (chan_b_out_en_n),
      .twos         (twos),
      .analog_code  (chan_b_code),
      .analog_range (chan_b_range),
      .sample_tick  (tick_b),
      .result       (res_b),
      .power_state  (pst_b)
   );

   ////////////////////////////////////////////////////////////////////
   // Events: delivered out-of-range sample, power state change
   always_comb begin
      events = 4'h0;
      events[conv_port_pkg::IRQ_OVR_A]  = tick_a & res_a.range;
      events[conv_port_pkg::IRQ_OVR_B]  = tick_b & res_b.range;
      events[conv_port_pkg::IRQ_MODE_A] = pst_a != st_reg.pst_a_d;
      events[conv_port_pkg::IRQ_MODE_B] = pst_b != st_reg.pst_b_d;
      live = {pst_b, pst_a};
   end

   conv_apb_regs u_regs (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .ce        (ce),
      .psel      (psel),
      .penable   (penable),
      .pwrite    (pwrite),
      .paddr     (paddr),
      .pwdata    (pwdata),
      .prdata    (prdata),
      .pready    (pready),
      .pslverr   (pslverr),
      .events    (events),
      .live      (live),
      .fmt_level (fmt_level),
      .irq       (irq)
   );

   ////////////////////////////////////////////////////////////////////
   // Output routing; select is a level, so swapping lands one clock later, not at a sample edge
   always_comb begin
      st_next = st_reg;
      if (bus_select) begin
         st_next.bus_a = res_a;
         st_next.bus_b = res_b;
         st_next.oe_a  = pst_a == conv_port_pkg::ST_RUN;
         st_next.oe_b  = pst_b == conv_port_pkg::ST_RUN;
      end else begin
         st_next.bus_a = res_b;
         st_next.bus_b = res_a;
         st_next.oe_a  = pst_b == conv_port_pkg::ST_RUN;
         st_next.oe_b  = pst_a == conv_port_pkg::ST_RUN;
      end
      st_next.dcs = conv_port_pkg::dcs_on(fmt_level);
      // Last power state seen, for change events
      st_next.pst_a_d = pst_a;
      st_next.pst_b_d = pst_b;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // Drives only in run state; 12-bit, bit 11 most significant
   assign bus_a_data          = st_reg.bus_a.code;
   assign bus_b_data          = st_reg.bus_b.code;
   assign bus_a_data_oe       = {12{st_reg.oe_a}};
   assign bus_b_data_oe       = {12{st_reg.oe_b}};
   assign bus_a_range_flag    = st_reg.bus_a.range;
   assign bus_b_range_flag    = st_reg.bus_b.range;
   assign bus_a_range_flag_oe = st_reg.oe_a;
   assign bus_b_range_flag_oe = st_reg.oe_b;
   assign stabilizer_on       = st_reg.dcs;

endmodule
`default_nettype wire

// >>> capture_rx.sv
`timescale 1ns/1ns
`default_nettype none
module capture_rx (
   // Clock
   input  wire logic        clk,
   // Pins from the converter
   input  wire logic [11:0] data,
   input  wire logic [11:0] data_oe,
   input  wire logic        flag,
   input  wire logic        flag_oe,
   // Level seen by the receiver, flag on top
   output logic [12:0]      level
);
   logic [12:0] last;
   // No pull on these lines, so a released line flips to the opposite level on every clock
   always_comb begin
      level[11:0] = (data & data_oe) | (~last[11:0] & ~data_oe);
      level[12]   = flag_oe ? flag : ~last[12];
   end
   always_ff @(posedge clk) last <= level;
endmodule
`default_nettype wire

// >>> dual_adc_output_port_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module dual_adc_output_port_checker (
   // Clock and reset
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        ce,
   // APB answer
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   // Channel controls
   input wire logic        bus_select,
   input wire logic        chan_a_power_down,
   input wire logic        chan_b_power_down,
   input wire logic        chan_a_out_en_n,
   input wire logic        chan_b_out_en_n,
   // Output enables
   input wire logic [11:0] bus_a_data_oe,
   input wire logic        bus_a_range_flag_oe,
   input wire logic [11:0] bus_b_data_oe,
   input wire logic        bus_b_range_flag_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Channel converting with its outputs on
   wire a_live = !chan_a_power_down && !chan_a_out_en_n;
   wire b_live = !chan_b_power_down && !chan_b_out_en_n;
   /////////////////////////////////////////////////////////////////////////
   // Drive follows routing one clock later, power levels two clocks later
   property p_straight;
      (ce && a_live) ##1 (ce && bus_select && a_live)
         |=> bus_a_data_oe == 12'hfff;
   endproperty
   a_straight: assert property (p_straight)
      else $error("bus A idle");
   property p_swap;
      (ce && b_live) ##1 (ce && !bus_select && b_live)
         |=> bus_a_data_oe == 12'hfff;
   endproperty
   a_swap: assert property (p_swap)
      else $error("bus A not from B");
   property p_oe_b;
      (ce && b_live) ##1 (ce && bus_select && b_live)
         |=> bus_b_data_oe == 12'hfff && bus_b_range_flag_oe;
   endproperty
   a_oe_b: assert property (p_oe_b)
      else $error("bus B idle");
   property p_hiz;
      (ce && chan_a_out_en_n) ##1 (ce && !bus_select && chan_a_out_en_n)
         |=> bus_b_data_oe == 12'h000 && !bus_b_range_flag_oe;
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("bus B driven");
   property p_nap;
      (ce && chan_a_power_down) ##1 (ce && !bus_select && chan_a_power_down)
         |=> bus_b_data_oe == 12'h000;
   endproperty
   a_nap: assert property (p_nap)
      else $error("bus B driven in nap");
   // Bus answer is a single wait state, one cycle wide
   property p_answer;
      ce && psel && penable && !pready |=> pready;
   endproperty
   a_answer: assert property (p_answer) else $error("late answer");
   property p_ready;
      pready |=> !pready;
   endproperty
   a_ready: assert property (p_ready) else $error("ready too long");
   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err) else $error("error without ready");
   cover property (ce && !bus_select && a_live);
   cover property (pslverr);
   cover property (ce && chan_a_power_down && chan_a_out_en_n);
endmodule
bind dual_adc_output_port dual_adc_output_port_checker u_checker (.*);
`default_nettype wire

// >>> dual_adc_output_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dual_adc_output_port_tb;
   localparam logic [11:0] A_STAT = 12'(conv_port_pkg::REG_STATUS);
   localparam logic [11:0] A_MASK = 12'(conv_port_pkg::REG_MASK);
   localparam logic [11:0] A_CTRL = 12'(conv_port_pkg::REG_CTRL);
   localparam int          LAT    = conv_port_pkg::LATENCY;
   // Stimulus
   logic        clk = 0, sys_rst = 1, ce = 1, psel = 0, penable = 0;
   logic        pwrite = 0, bus_select = 1, chan_a_range = 0, chan_b_range = 0;
   logic        chan_a_sample_clock = 0, chan_b_sample_clock = 0;
   logic        chan_a_power_down = 0, chan_b_power_down = 0;
   logic        chan_a_out_en_n = 0, chan_b_out_en_n = 0;
   logic [11:0] paddr = '0, chan_a_code = '0, chan_b_code = '0;
   logic [31:0] pwdata = '0;
   // Design outputs and resolved pins
   logic [31:0] prdata, rd;
   logic        pready, pslverr, irq, stabilizer_on, er;
   logic        bus_a_range_flag, bus_a_range_flag_oe;
   logic        bus_b_range_flag, bus_b_range_flag_oe;
   logic [11:0] bus_a_data, bus_a_data_oe, bus_b_data, bus_b_data_oe;
   logic [12:0] wire_a, wire_b;
   // Reference model: captured {range, code} per channel, format
   logic [12:0] qa[$], qb[$];
   logic [1:0]  fmt = '0;
   int          err_total = 0, checks = 0, cyc = 0;
   dual_adc_output_port u_dut (.*);
   capture_rx u_rx_a (.clk(clk), .data(bus_a_data), .data_oe(bus_a_data_oe),
      .flag(bus_a_range_flag), .flag_oe(bus_a_range_flag_oe), .level(wire_a));
   capture_rx u_rx_b (.clk(clk), .data(bus_b_data), .data_oe(bus_b_data_oe),
      .flag(bus_b_range_flag), .flag_oe(bus_b_range_flag_oe), .level(wire_b));
   always #4 clk = ~clk;
   /////////////////////////////////////////////////////////////////////////
   task automatic cmp(input string nm, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Power code expected for one channel
   function automatic logic [1:0] pc(input logic pd, oen);
      return pd ? {1'b1, ~oen} : {1'b0, oen};
   endfunction
   // One APB transfer, held until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Result on the bus is the capture five sample edges back
   task automatic chk_bus(input logic s);
      logic [12:0] m;
      m = {1'b0, fmt[1], 11'h000};
      if (qa.size() > LAT && !chan_a_power_down && !chan_a_out_en_n)
         cmp("bus_of_a", qa[$-LAT] ^ m,
             s ? wire_a : wire_b);
      if (qb.size() > LAT && !chan_b_power_down && !chan_b_out_en_n)
         cmp("bus_of_b", qb[$-LAT] ^ m,
             s ? wire_b : wire_a);
   endtask
   // Sample clocks high then low, select per phase, new codes while low
   task automatic samples(input int n, input logic sh, sl, input int rm);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         chan_a_sample_clock <= 1'b1;
         chan_b_sample_clock <= 1'b1;
         bus_select <= sh;
         if (!chan_a_power_down) qa.push_back({chan_a_range, chan_a_code});
         if (!chan_b_power_down) qb.push_back({chan_b_range, chan_b_code});
         repeat (6) @(posedge clk);
         chk_bus(sh);
         chan_a_sample_clock <= 1'b0;
         chan_b_sample_clock <= 1'b0;
         bus_select <= sl;
         chan_a_code <= 12'($urandom);
         chan_b_code <= 12'($urandom);
         chan_a_range <= rm == 2 || (rm == 0 && $urandom_range(3) == 0);
         chan_b_range <= rm == 0 && $urandom_range(3) == 0;
         repeat (6) @(posedge clk);
         chk_bus(sl);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Hang guard, far above the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         err_total++;
         results();
      end
   end
   initial begin
      void'($urandom(15088));
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 16; a += 4) begin
         apb(1'b0, 12'(a), '0);
         cmp("read_err", 32'(a == 12), 32'(er));
         if (a < 12) cmp("reset_value", '0, rd);
      end
      $display("test reset done");
      for (int f = 0; f < 4; f++) begin
         fmt = 2'(f);
         apb(1'b1, A_CTRL, 32'(f));
         repeat (3) @(posedge clk);
         cmp("stabilizer", 32'(f == 1 || f == 2), 32'(stabilizer_on));
         qa.delete();
         qb.delete();
         samples(7, f[0], f[0], 0);
         $display("test format %0d done", f);
      end
      samples(8, 1'b1, 1'b0, 0);
      $display("test interleave done");
      for (int m = 0; m < 4; m++) begin
         chan_a_power_down <= m[1];
         chan_a_out_en_n   <= m[0];
         chan_b_power_down <= !m[1];
         chan_b_out_en_n   <= !m[0];
         samples(2, 1'b0, 1'b0, 0);
         cmp("oe_of_a", m == 0 ? 13'h1fff : '0,
             {bus_b_range_flag_oe, bus_b_data_oe});
         apb(1'b0, A_STAT, '0);
         cmp("live", {pc(!m[1], !m[0]), pc(m[1], m[0])}, rd[7:4]);
      end
      chan_a_power_down <= 1'b0;
      chan_a_out_en_n   <= 1'b0;
      chan_b_power_down <= 1'b0;
      chan_b_out_en_n   <= 1'b0;
      samples(6, 1'b1, 1'b1, 1);
      $display("test power done");
      apb(1'b1, A_STAT, 32'h0000_000f);
      apb(1'b0, A_STAT, '0);
      cmp("status_clear", '0, rd[3:0]);
      samples(1, 1'b1, 1'b1, 2);
      samples(6, 1'b1, 1'b1, 1);
      apb(1'b0, A_STAT, '0);
      cmp("status_ovr", 32'h0000_0001, rd[3:0]);
      cmp("irq_masked", '0, irq);
      apb(1'b1, A_MASK, 32'h0000_0001);
      repeat (2) @(posedge clk);
      cmp("irq_set", 32'h0000_0001, irq);
      apb(1'b1, A_STAT, 32'h0000_0001);
      repeat (2) @(posedge clk);
      cmp("irq_clear", '0, irq);
      $display("test interrupt done");
      results();
   end
endmodule
`default_nettype wire
